// ===== rtl/itr_map.vh
/*
  register map, field positions, reset values and timing counts of the i2c master
  transaction-request block.
  assumes a 25 MHz system clock and a plain strobe register port with 8-bit addresses.
*/
`ifndef ITR_MAP_VH
`define ITR_MAP_VH

`define ITR_ADDR_REQ 8'h8b
`define ITR_ADDR_CFG 8'h80
`define ITR_ADDR_PTR 8'h81
`define ITR_ADDR_BUF01 8'h82
`define ITR_ADDR_BUF23 8'h83
`define ITR_ADDR_STAT 8'h84
`define ITR_ADDR_MASK 8'h85

`define ITR_REQ_RESET 16'h2800
`define ITR_F_PSEL 15
`define ITR_F_LEN_HI 14
`define ITR_F_LEN_LO 13
`define ITR_F_SLOT_HI 12
`define ITR_F_SLOT_LO 11
`define ITR_F_EXT_HI 10
`define ITR_F_EXT_LO 8
`define ITR_F_ADDR_HI 7
`define ITR_F_ADDR_LO 1
`define ITR_F_DIR 0

`define ITR_CFG_ALT 0
`define ITR_CFG_ADDR10 1
`define ITR_CFG_PTRLEN 2

`define ITR_ST_DONE 0
`define ITR_ST_NACK 1
`define ITR_ST_REJECT 2

`define ITR_CLK_HZ 25000000
`define ITR_SCL_HZ 100000
`define ITR_QTR_CYC (`ITR_CLK_HZ / (4 * `ITR_SCL_HZ))

`endif

// ===== rtl/itr_qtr_tick.v
/*
  enable divider giving one-cycle pulses at four times the scl rate.
  assumes a single clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module itr_qtr_tick #(
  parameter integer DIV = 62
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // control
  input wire run,
  output reg tick
);
  reg [15:0] cnt_q;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 16'h0000;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_q <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt_q == DIV[15:0] - 16'h0001) begin
      cnt_q <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/itr_master.v
/*
  transaction-request register with its i2c master engine, buffers and interrupt.
  assumes a strobe register port on clk and open-drain scl and sda pins outside.
*/
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "itr_map.vh"
module itr_master #(
  parameter integer QTR_CYC = `ITR_QTR_CYC
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // register port
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // interrupt
  output wire irq,
  // i2c pins
  input wire scl_in,
  output wire scl_out,
  output wire scl_oe,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe
);
  localparam [3:0] S_IDLE = 4'h0, S_START = 4'h1, S_BYTE = 4'h2, S_ACK = 4'h3;
  localparam [3:0] S_RSTART = 4'h4, S_STOP = 4'h5, S_DONE = 4'h6;

  reg [15:0] req_q;
  reg [2:0] cfg_q;
  reg [15:0] ptr_q;
  reg [7:0] buf_q [0:3];
  reg [2:0] stat_q;
  reg [2:0] mask_q;
  reg [3:0] st_q;
  reg [1:0] ph_q;
  reg [2:0] bit_q;
  reg [7:0] sh_q;
  reg [3:0] seq_q;
  reg [2:0] dcnt_q;
  reg [1:0] didx_q;
  reg rd_phase_q;
  reg scl_low_q;
  reg sda_low_q;
  reg sda_m_q;
  reg sda_s_q;
  reg scl_m_q;
  reg scl_s_q;
  reg done_p;
  reg nack_p;
  wire tick;
  wire busy = (st_q != S_IDLE);
  wire wr_req = reg_wr && (reg_addr == `ITR_ADDR_REQ);
  wire accept = wr_req && !busy;
  wire reject = wr_req && busy;
  integer i;

  // byte count of the current request, alt write mode aware
  function [2:0] data_len;
    input [1:0] code;
    input dir_rd;
    input alt;
    begin
      case (code)
        2'b00: data_len = 3'd1;
        2'b01: data_len = 3'd2;
        2'b10: data_len = (alt && !dir_rd) ? 3'd0 : 3'd3;
        default: data_len = 3'd4;
      endcase
    end
  endfunction

  itr_qtr_tick #(.DIV(QTR_CYC)) u_tick (
    .clk(clk),
    .reset_n(reset_n),
    .run(busy),
    .tick(tick)
  );

  // pin synchronisers
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
    end else begin
      sda_m_q <= sda_in;
      sda_s_q <= sda_m_q;
      scl_m_q <= scl_in;
      scl_s_q <= scl_m_q;
    end
  end

  // register writes; software clears status by writing one, hardware set wins
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_q <= `ITR_REQ_RESET;
      cfg_q <= 3'h0;
      ptr_q <= 16'h0000;
      mask_q <= 3'h0;
      stat_q <= 3'h0;
    end else begin
      if (accept)
        req_q <= reg_wdata;
      if (reg_wr && reg_addr == `ITR_ADDR_CFG)
        cfg_q <= reg_wdata[2:0];
      if (reg_wr && reg_addr == `ITR_ADDR_PTR)
        ptr_q <= reg_wdata;
      if (reg_wr && reg_addr == `ITR_ADDR_MASK)
        mask_q <= reg_wdata[2:0];
      stat_q <= (stat_q & ~((reg_wr && reg_addr == `ITR_ADDR_STAT) ? reg_wdata[2:0] : 3'h0))
        | {reject, nack_p, done_p};
    end
  end

  assign irq = |(stat_q & mask_q);

  // read port, data one cycle after the strobe
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `ITR_ADDR_REQ: reg_rdata <= req_q;
        `ITR_ADDR_CFG: reg_rdata <= {13'h0000, cfg_q};
        `ITR_ADDR_PTR: reg_rdata <= ptr_q;
        `ITR_ADDR_BUF01: reg_rdata <= {buf_q[0], buf_q[1]};
        `ITR_ADDR_BUF23: reg_rdata <= {buf_q[2], buf_q[3]};
        `ITR_ADDR_STAT: reg_rdata <= {12'h000, busy, stat_q};
        `ITR_ADDR_MASK: reg_rdata <= {13'h0000, mask_q};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // sequence slots: 0 addr(+w), 1 10-bit low addr, 2 ptr0, 3 ptr1, 4 restart addr(+r), 5 data
  wire addr10 = cfg_q[`ITR_CFG_ADDR10];
  wire dir_rd = req_q[`ITR_F_DIR];
  wire [9:0] taddr = {addr10 ? req_q[`ITR_F_EXT_HI:`ITR_F_EXT_LO] : 3'b000,
    req_q[`ITR_F_ADDR_HI:`ITR_F_ADDR_LO]};
  wire [7:0] hdr10 = {5'b11110, taddr[9:8], 1'b0};
  wire two_ptr = cfg_q[`ITR_CFG_PTRLEN];
  wire [7:0] one_ptr = req_q[`ITR_F_PSEL] ? ptr_q[15:8] : ptr_q[7:0];

  // byte to load for the next slot
  function [7:0] slot_byte;
    input [3:0] s;
    input [7:0] dbyte;
    begin
      case (s)
        4'd0: slot_byte = addr10 ? hdr10 : {taddr[6:0], dir_rd && !two_ptr_used(1'b0)};
        4'd1: slot_byte = taddr[7:0];
        4'd2: slot_byte = two_ptr ? ptr_q[7:0] : one_ptr;
        4'd3: slot_byte = ptr_q[15:8];
        4'd4: slot_byte = addr10 ? {hdr10[7:1], 1'b1} : {taddr[6:0], 1'b1};
        default: slot_byte = dbyte;
      endcase
    end
  endfunction

  // pointer phase is always sent: reads are combined format
  function two_ptr_used;
    input dummy;
    begin
      two_ptr_used = 1'b1;
    end
  endfunction

  // next slot after s
  function [3:0] next_slot;
    input [3:0] s;
    begin
      case (s)
        4'd0: next_slot = addr10 ? 4'd1 : 4'd2;
        4'd1: next_slot = 4'd2;
        4'd2: next_slot = two_ptr ? 4'd3 : (dir_rd ? 4'd4 : 4'd5);
        4'd3: next_slot = dir_rd ? 4'd4 : 4'd5;
        default: next_slot = 4'd5;
      endcase
    end
  endfunction

  // bit engine, four quarter phases per scl bit
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= S_IDLE;
      ph_q <= 2'd0;
      bit_q <= 3'd0;
      sh_q <= 8'h00;
      seq_q <= 4'd0;
      dcnt_q <= 3'd0;
      didx_q <= 2'd0;
      rd_phase_q <= 1'b0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      done_p <= 1'b0;
      nack_p <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
        buf_q[i] <= 8'h00;
    end else begin
      done_p <= 1'b0;
      nack_p <= 1'b0;
      if (reg_wr && reg_addr == `ITR_ADDR_BUF01 && !busy) begin
        buf_q[0] <= reg_wdata[15:8];
        buf_q[1] <= reg_wdata[7:0];
      end
      if (reg_wr && reg_addr == `ITR_ADDR_BUF23 && !busy) begin
        buf_q[2] <= reg_wdata[15:8];
        buf_q[3] <= reg_wdata[7:0];
      end
      case (st_q)
        S_IDLE: begin
          if (accept) begin
            st_q <= S_START;
            ph_q <= 2'd0;
          end
        end
        S_START: if (tick) begin
          ph_q <= ph_q + 2'd1;
          if (ph_q == 2'd0)
            sda_low_q <= 1'b1;
          if (ph_q == 2'd2) begin
            scl_low_q <= 1'b1;
            st_q <= S_BYTE;
            ph_q <= 2'd0;
            bit_q <= 3'd7;
            seq_q <= 4'd0;
            rd_phase_q <= 1'b0;
            dcnt_q <= data_len(req_q[`ITR_F_LEN_HI:`ITR_F_LEN_LO], dir_rd,
              cfg_q[`ITR_CFG_ALT]);
            didx_q <= req_q[`ITR_F_SLOT_HI:`ITR_F_SLOT_LO];
            sh_q <= slot_byte(4'd0, 8'h00);
          end
        end
        S_RSTART: if (tick) begin
          ph_q <= ph_q + 2'd1;
          case (ph_q)
            2'd0: sda_low_q <= 1'b0;
            2'd1: scl_low_q <= 1'b0;
            2'd2: sda_low_q <= 1'b1;
            default: begin
              scl_low_q <= 1'b1;
              st_q <= S_BYTE;
              bit_q <= 3'd7;
            end
          endcase
        end
        S_BYTE: if (tick) begin
          ph_q <= ph_q + 2'd1;
          case (ph_q)
            2'd0: sda_low_q <= rd_phase_q ? 1'b0 : !sh_q[7];
            2'd1: scl_low_q <= 1'b0;
            2'd2: if (scl_s_q) sh_q <= {sh_q[6:0], sda_s_q};
            default: begin
              scl_low_q <= 1'b1;
              bit_q <= bit_q - 3'd1;
              if (bit_q == 3'd0)
                st_q <= S_ACK;
            end
          endcase
          if (ph_q == 2'd2 && !scl_s_q)
            ph_q <= ph_q; // clock stretch by the target
        end
        S_ACK: if (tick) begin
          ph_q <= ph_q + 2'd1;
          case (ph_q)
            2'd0: sda_low_q <= rd_phase_q && (dcnt_q != 3'd1);
            2'd1: scl_low_q <= 1'b0;
            2'd2: begin
              if (!scl_s_q)
                ph_q <= ph_q;
              else if (rd_phase_q) begin
                buf_q[didx_q] <= sh_q;
                didx_q <= didx_q + 2'd1;
                dcnt_q <= dcnt_q - 3'd1;
              end else if (sda_s_q) begin
                nack_p <= 1'b1;
                st_q <= S_STOP;
                ph_q <= 2'd0;
                scl_low_q <= 1'b1;
              end
            end
            default: begin
              scl_low_q <= 1'b1;
              ph_q <= 2'd0;
              bit_q <= 3'd7;
              if (rd_phase_q) begin
                st_q <= (dcnt_q == 3'd0) ? S_STOP : S_BYTE;
              end else if (seq_q == 4'd5) begin
                dcnt_q <= dcnt_q - 3'd1;
                didx_q <= didx_q + 2'd1;
                sh_q <= buf_q[didx_q + 2'd1];
                st_q <= (dcnt_q == 3'd1) ? S_STOP : S_BYTE;
              end else if (seq_q == 4'd4) begin
                rd_phase_q <= 1'b1;
                st_q <= (dcnt_q == 3'd0) ? S_STOP : S_BYTE;
              end else begin
                seq_q <= next_slot(seq_q);
                sh_q <= slot_byte(next_slot(seq_q), buf_q[didx_q]);
                if (next_slot(seq_q) == 4'd4)
                  st_q <= S_RSTART;
                else if (next_slot(seq_q) == 4'd5 && dcnt_q == 3'd0)
                  st_q <= S_STOP;
                else
                  st_q <= S_BYTE;
              end
            end
          endcase
        end
        S_STOP: if (tick) begin
          ph_q <= ph_q + 2'd1;
          case (ph_q)
            2'd0: sda_low_q <= 1'b1;
            2'd1: scl_low_q <= 1'b0;
            2'd2: sda_low_q <= 1'b0;
            default: st_q <= S_DONE;
          endcase
        end
        S_DONE: begin
          done_p <= 1'b1;
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // open drain: only ever pull low
  assign scl_out = 1'b0;
  assign scl_oe = scl_low_q;
  assign sda_out = 1'b0;
  assign sda_oe = sda_low_q;
endmodule
`default_nettype wire

// ===== bench/itr_tgt.sv
/* i2c target model: acks and logs written bytes, reads give a5 plus a count.
   assumes the bench resolves scl and sda with pull-ups */
`timescale 1ns/100ps
`default_nettype none
module itr_tgt (
  // bus lines
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe
);
  int b = -9;
  bit rd, fst;
  logic [7:0] sh, tx;
  logic [7:0] n = 8'h0;
  logic [7:0] q [$];
  initial sda_oe = 0;
  always @(negedge sda) if (scl) begin
    b = -1;
    fst = 1;
  end
  always @(posedge sda) if (scl) begin
    b = -9;
    rd = 0;
  end
  always @(posedge scl) if (b >= 0) begin
    if (b < 8) sh = {sh[6:0], sda};
    else if (sda) rd = 0; // a master nack ends the read
  end
  always @(negedge scl) if (b > -9) begin
    b++;
    if (b == 8) begin
      sda_oe = !rd;
      if (!rd) q.push_back(sh);
    end else if (b == 9) begin
      if (fst) rd = sh[0];
      fst = 0;
      b = 0;
      tx = 8'ha5 + n;
      if (rd) n++;
      sda_oe = rd && !tx[7];
    end else if (rd && b < 8) sda_oe = !tx[7 - b];
  end
endmodule
`default_nettype wire

// ===== bench/itr_master_properties.sv
/* port assertions for the request master.
   assumes one clock and the async low reset */
`timescale 1ns/100ps
`default_nettype none
module itr_chk #(
  parameter integer QTR_CYC = 62
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // interrupt and pins
  input wire logic irq,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe
);
  logic [15:0] msk_q;
  logic [15:0] age_q;
  wire req_w = reg_wr && reg_addr == 8'h8b;
  wire st_r = reg_rd && reg_addr == 8'h84;
  // age saturates so a stuck engine is still caught
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      msk_q <= 16'h0;
      age_q <= 16'h0;
    end else begin
      if (reg_wr && reg_addr == 8'h85) msk_q <= reg_wdata;
      if (req_w) age_q <= 16'h0;
      else if (age_q != 16'hffff) age_q <= age_q + 16'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_rdata_slot: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
    else $error("read data outside slot");
  a_pins_low: assert property (!scl_out && !sda_out)
    else $error("pin driven high");
  a_unmapped_zero: assert property (reg_rd && reg_addr != 8'h8b
    && (reg_addr < 8'h80 || reg_addr > 8'h85) |=> reg_rdata == 16'h0)
    else $error("unmapped read not zero");
  a_irq_masked: assert property (msk_q == 16'h0 |-> !irq)
    else $error("irq while masked");
  a_reset_idle: assert property ($rose(reset_n) |-> !scl_oe && !sda_oe)
    else $error("bus driven at reset");
  a_drive_req: assert property (scl_oe || sda_oe |-> age_q < 16'(400 * QTR_CYC))
    else $error("bus driven without request");
  a_reject_flag: assert property (req_w ##1 req_w ##1 st_r |=> reg_rdata[2])
    else $error("busy write not flagged");
  a_reject_keep: assert property (req_w ##1 req_w ##1 st_r ##1
    reg_rd && reg_addr == 8'h8b |=> reg_rdata != $past(reg_wdata, 3)
    || $past(reg_wdata, 3) == $past(reg_wdata, 4))
    else $error("busy write changed request");
  c_reject: cover property (req_w ##1 req_w);
  c_irq: cover property (irq);
  c_xfer: cover property ($rose(scl_oe));
endmodule
bind itr_master itr_chk #(.QTR_CYC(QTR_CYC)) itr_chk_i (
  .clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
  .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe
);
`default_nettype wire

// ===== bench/i2c_master_transaction_request_test.sv
/* self-checking bench for the request master.
   assumes pull-ups on scl and sda and the itr_tgt model */
`timescale 1ns/100ps
`default_nettype none
module i2c_master_transaction_request_test;
  logic clk, reset_n, reg_wr, reg_rd;
  logic [7:0] reg_addr, rn;
  logic [15:0] reg_wdata, p, v;
  wire [15:0] reg_rdata;
  wire irq, scl_oe, sda_oe, t_oe;
  wire scl_in = !scl_oe;
  wire sda_in = !(sda_oe || t_oe);
  int fails, n_checks, cyc, i;
  itr_master #(.QTR_CYC(2)) itr_master_i (
    .clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .scl_in, .scl_out(), .scl_oe, .sda_in, .sda_out(), .sda_oe);
  itr_tgt itr_tgt_i (.scl(scl_in), .sda(sda_in), .sda_oe(t_oe));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t saw %h want %h", $time, s, e);
    end
  endtask
  task print_verdict;
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    @(posedge clk);
    d = reg_rdata;
  endtask
  task automatic wait_done(input logic [15:0] e);
    int k;
    v = 0;
    for (k = 0; k < 3000 && v[0] !== 1'b1; k++) rd(8'h84, v);
    chk(v & 16'h7, e);
    wr(8'h84, 16'h7);
  endtask
  // m: bit3 10-bit and alt write, bit2 read, bits1:0 length code
  task automatic xfer(input logic [3:0] m);
    logic [7:0] bf [4];
    logic [7:0] e [$];
    logic [15:0] q;
    int n, s, j;
    bit t;
    q = $urandom;
    q[14:13] = m[1:0];
    q[0] = m[2];
    // two-byte pointer only with 7-bit targets keeps the longest frame short
    t = !m[3] && $urandom_range(1);
    p = $urandom;
    for (j = 0; j < 4; j++) bf[j] = $urandom;
    wr(8'h80, {13'h0, t, m[3], m[3]});
    wr(8'h81, p);
    wr(8'h82, {bf[0], bf[1]});
    wr(8'h83, {bf[2], bf[3]});
    itr_tgt_i.q.delete();
    wr(8'h8b, q);
    wait_done(16'h1);
    e.push_back(m[3] ? {5'h1e, q[10:9], 1'b0} : {q[7:1], 1'b0});
    if (m[3]) e.push_back(q[8:1]);
    if (t) begin
      e.push_back(p[7:0]);
      e.push_back(p[15:8]);
    end else begin
      e.push_back(q[15] ? p[15:8] : p[7:0]);
    end
    n = (m[3] && q[14:13] == 2 && !q[0]) ? 0 : q[14:13] + 1;
    s = q[12:11];
    if (q[0]) e.push_back({e[0][7:1], 1'b1});
    for (j = 0; j < n; j++) begin
      if (q[0]) bf[(s + j) % 4] = 8'ha5 + rn++;
      else e.push_back(bf[(s + j) % 4]);
    end
    chk(16'(itr_tgt_i.q.size()), 16'(e.size()));
    for (j = 0; j < e.size() && j < itr_tgt_i.q.size(); j++) begin
      chk({8'h0, itr_tgt_i.q[j]}, {8'h0, e[j]});
    end
    rd(8'h82, v);
    chk(v, {bf[0], bf[1]});
    rd(8'h83, v);
    chk(v, {bf[2], bf[3]});
    rd(8'h8b, v);
    chk(v, q);
  endtask
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  // a transfer takes under a thousand cycles at the shortened bit time
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      print_verdict;
    end
  end
  initial begin
    reset_n = 0;
    reg_wr = 0;
    reg_rd = 0;
    reg_addr = 0;
    reg_wdata = 0;
    rn = 0;
    v = $urandom(32'h042f);
    repeat (10) @(posedge clk);
    reset_n <= 1;
    @(posedge clk);
    rd(8'h8b, v);
    chk(v, 16'h2800);
    rd(8'h8c, v);
    chk(v, 16'h0);
    for (i = 0; i < 16; i++) xfer(i[3:0]);
    wr(8'h85, 16'h4);
    p = $urandom;
    p[0] = 0;
    reg_addr <= 8'h8b;
    reg_wdata <= p;
    reg_wr <= 1;
    @(posedge clk);
    reg_wdata <= p ^ 16'h00fe;
    @(posedge clk);
    reg_wr <= 0;
    reg_rd <= 1;
    reg_addr <= 8'h84;
    @(posedge clk);
    reg_addr <= 8'h8b;
    @(posedge clk);
    reg_rd <= 0;
    chk(reg_rdata & 16'h4, 16'h4);
    @(posedge clk);
    chk(reg_rdata, p);
    chk({15'h0, irq}, 16'h1);
    wr(8'h85, 16'h0);
    chk({15'h0, irq}, 16'h0);
    wr(8'h85, 16'h4);
    wait_done(16'h5);
    chk({15'h0, irq}, 16'h0);
    // mid-run reset with the bus idle must bring the request word back
    reset_n <= 0;
    repeat (2) @(posedge clk);
    reset_n <= 1;
    @(posedge clk);
    rd(8'h8b, v);
    chk(v, 16'h2800);
    print_verdict;
  end
endmodule
`default_nettype wire
